// ==== include/xpp_pkg.sv ====
// Purpose: shared constants of the crosspoint programming port
// Assumes: one system clock of 250 MHz on both ends
// Notes:   slot k of the word holds bits [4k+3:4k], select msb on top

package xpp_pkg;

  // ==========================================================
  // matrix shape
  localparam int NUM_OUT   = 8;
  localparam int NUM_IN    = 8;
  localparam int SEL_W     = 3;
  localparam int ADDR_W    = 3;
  localparam int GRP_W     = 4;
  localparam int WORD_W    = NUM_OUT * GRP_W;
  localparam int CNT_W     = 5;

  // ==========================================================
  // field positions inside one four-bit slot
  localparam int EN_POS    = 0;
  localparam int SEL_LSB   = 1;

  // ==========================================================
  // values after reset
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 5'h00;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_HALF_NS  = 20;
  localparam int UPD_LOW_NS    = 20;
  localparam int PROG_HALF_CYC = (PROG_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UPD_LOW_CYC   = (UPD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = 8;
  localparam int SYNC_W        = 5 + ADDR_W + SEL_W + 1;

  // ==========================================================
  // synchroniser value after reset: clock, select, update idle high
  localparam logic [SYNC_W-1:0] PINS_RST = {4'hb, {(SYNC_W-4){1'b0}}};

endpackage

// ==== include/xpp_link_if.sv ====
// Purpose: programming pins between host logic and the crosspoint
// Assumes: all pins single direction, host drives all but ser_dout
// Notes:   outputs_off_n is the active-low disable pin

`timescale 1ns/10ps

interface xpp_link_if;
  import xpp_pkg::*;

  logic               prog_clk;
  logic               ser_din;
  logic               ser_dout;
  logic               cs_n;
  logic               update_n;
  logic               load_mode_select;
  logic [ADDR_W-1:0]  out_addr;
  logic [SEL_W-1:0]   src_sel;
  logic               output_enable_bit;
  logic               outputs_off_n;

  modport device (
    input  prog_clk,
    input  ser_din,
    output ser_dout,
    input  cs_n,
    input  update_n,
    input  load_mode_select,
    input  out_addr,
    input  src_sel,
    input  output_enable_bit,
    input  outputs_off_n
  );

  modport host (
    output prog_clk,
    output ser_din,
    input  ser_dout,
    output cs_n,
    output update_n,
    output load_mode_select,
    output out_addr,
    output src_sel,
    output output_enable_bit,
    output outputs_off_n
  );

endinterface

// ==== rtl/xpp_device.sv ====
// Purpose: device end of the crosspoint programming port
// Assumes: pins arrive asynchronously; all but outputs_off_n pass two flip-flops
// Notes:   update latches modelled as flops that follow while open

`timescale 1ns/10ps

//
// Contract
// - serial load is 32 bits, reprograms all
// - host drives mode low for serial loading
// - clocked data accepted only with select low
// - shifting continues while update low, matrix follows
// - sample serial bit on each falling clock edge
// - four bits per output: three select, enable
// - enable zero disables output, select ignored
// - host shifts highest output group first
// - update low with select low opens latches, otherwise they hold
// - serial output shows bit leaving shift register
// - chain: last device first, 32 bits each
// - parallel write changes one output only
// - reset pin disables outputs, keeps registers
// - host programs all outputs after power-up
// - no select plus update low before loading
// - parallel setup: mode, update, clock high
// - address pins pick the written output slot
// - falling edge captures parallel slot, update applies
// - host may batch writes, one update
// - address and select bit zero least significant
// - reset pin low holds outputs disabled
module xpp_device
  import xpp_pkg::*;
(
  input  wire logic                          mclk_i,
  input  wire logic                          reset_n_i,
  xpp_link_if.device                         link,
  output logic [NUM_OUT-1:0]                 out_en_o,
  output logic [NUM_OUT-1:0][SEL_W-1:0]      out_sel_o,
  output logic [NUM_OUT-1:0][NUM_IN-1:0]     xpoint_o,
  output logic [WORD_W-1:0]                  shift_word_o,
  output logic                               frame_done_o,
  output logic                               par_write_o
);

  // ==========================================================
  // pin synchroniser
  logic [SYNC_W-1:0]         pins_raw;
  logic [SYNC_W-1:0]         pins_s1;
  logic [SYNC_W-1:0]         pins_s2;
  logic                      clk_s;
  logic                      clk_prev;
  logic                      din_s;
  logic                      cs_n_s;
  logic                      upd_n_s;
  logic                      mode_s;
  logic [ADDR_W-1:0]         addr_s;
  logic [SEL_W-1:0]          sel_s;
  logic                      en_s;
  logic                      fall;
  logic                      ser_shift;
  logic                      par_load;
  logic                      latch_open;

  // bundle order fixes the unpack order further down
  assign pins_raw = {link.prog_clk,
                     link.ser_din,
                     link.cs_n,
                     link.update_n,
                     link.load_mode_select,
                     link.out_addr,
                     link.src_sel,
                     link.output_enable_bit};

  // first stage is read only by the second stage
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // idle levels, else release shows a fall and an open latch
      pins_s1 <= PINS_RST;
      pins_s2 <= PINS_RST;
    end else begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
    end
  end

  // same order as the raw bundle
  assign {clk_s,
          din_s,
          cs_n_s,
          upd_n_s,
          mode_s,
          addr_s,
          sel_s,
          en_s} = pins_s2;

  // clock sits high at reset so release causes no false edge
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= clk_s;
    end
  end

  // ==========================================================
  // edge and strobe decode
  // all synchronised pins share the same latency, so data aligns with the edge
  assign fall       = clk_prev & ~clk_s;
  assign ser_shift  = fall & ~cs_n_s & ~mode_s;
  assign par_load   = fall & ~cs_n_s & mode_s;
  assign latch_open = ~cs_n_s & ~upd_n_s;

  // ==========================================================
  // shift register and update latches, one slot per output
  logic [WORD_W-1:0]         shift_word;
  logic [WORD_W-1:0]         latch_word;
  logic [NUM_OUT-1:0]        carry_in;
  logic [GRP_W-1:0]          par_slot;

  // select msb enters first and ends on top of the slot
  assign par_slot = {sel_s, en_s};
  assign carry_in[0] = din_s;

  genvar k;
  generate
    for (k = 0; k < NUM_OUT; k++) begin : g_slot
      // slot k is fed by the top bit of slot k-1
      if (k > 0) begin : g_carry
        assign carry_in[k] = shift_word[GRP_W*k-1];
      end

      // reset pin is not looked at here: registers survive it
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          shift_word[GRP_W*k +: GRP_W] <= WORD_RST[GRP_W*k +: GRP_W];
        end else if (ser_shift) begin
          shift_word[GRP_W*k +: GRP_W] <=
            {shift_word[GRP_W*k +: GRP_W-1], carry_in[k]};
        end else if (par_load && (addr_s == ADDR_W'(k))) begin
          shift_word[GRP_W*k +: GRP_W] <= par_slot;
        end
      end

      // open latches follow every shift, so host keeps update high
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          latch_word[GRP_W*k +: GRP_W] <= WORD_RST[GRP_W*k +: GRP_W];
        end else if (latch_open) begin
          latch_word[GRP_W*k +: GRP_W] <= shift_word[GRP_W*k +: GRP_W];
        end
      end

      // reset pin gates enables with no clock in the path
      assign out_en_o[k]  = latch_word[GRP_W*k+EN_POS] &
                            link.outputs_off_n;
      assign out_sel_o[k] = latch_word[GRP_W*k+SEL_LSB +: SEL_W];

      for (genvar j = 0; j < NUM_IN; j++) begin : g_in
        // disabled output has no input connected at all
        assign xpoint_o[k][j] = out_en_o[k] &
                                (out_sel_o[k] == SEL_W'(j));
      end
    end
  endgenerate

  // ==========================================================
  // serial output for the daisy chain
  assign link.ser_dout = shift_word[WORD_W-1];
  assign shift_word_o  = shift_word;

  // ==========================================================
  // frame tracking
  logic [CNT_W-1:0]          bit_cnt;
  logic [CNT_W-1:0]          next_bit_cnt;
  logic                      last_bit;

  // count restarts whenever select rises, a frame is one select window
  assign next_bit_cnt = bit_cnt + 5'h01;

  // count wraps to zero on the 32nd shift of a window
  assign last_bit = (bit_cnt == CNT_RST - 5'h01);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt <= CNT_RST;
    end else if (cs_n_s) begin
      bit_cnt <= CNT_RST;
    end else if (ser_shift) begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // pulse when a whole word has passed: every slot then rewritten
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_done_o <= 1'b0;
    end else begin
      frame_done_o <= ser_shift && last_bit;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // one pulse per accepted parallel write
      par_write_o <= 1'b0;
    end else begin
      par_write_o <= par_load;
    end
  end

endmodule

// ==== rtl/xpp_host.sv ====
// Purpose: host end that drives the crosspoint programming pins
// Assumes: one command at a time, accepted only while not busy
// Notes:   programming clock made by dividing mclk_i

`timescale 1ns/10ps

module xpp_host
  import xpp_pkg::*;
#(
  parameter int CHAIN_BITS = WORD_W,
  parameter int HALF_CYC   = PROG_HALF_CYC,
  parameter int UPD_CYC    = UPD_LOW_CYC
)
(
  input  wire logic                  mclk_i,
  input  wire logic                  reset_n_i,
  xpp_link_if.host                   link,
  input  wire logic                  cmd_serial_i,
  input  wire logic [CHAIN_BITS-1:0] serial_word_i,
  input  wire logic                  cmd_par_i,
  input  wire logic [ADDR_W-1:0]     par_addr_i,
  input  wire logic [SEL_W-1:0]      par_sel_i,
  input  wire logic                  par_en_i,
  input  wire logic                  cmd_update_i,
  input  wire logic                  outputs_off_i,
  output logic                       busy_o,
  output logic                       chain_out_o
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HI   = 4'b0010,
    ST_LO   = 4'b0100,
    ST_UPD  = 4'b1000
  } xpp_host_state_t;

  localparam logic [TICK_W-1:0] HALF_T = TICK_W'(HALF_CYC - 1);
  localparam logic [TICK_W-1:0] UPD_T  = TICK_W'(UPD_CYC - 1);

  xpp_host_state_t          state;
  logic [TICK_W-1:0]        tick;
  logic [15:0]              edges;
  logic [CHAIN_BITS-1:0]    word;
  logic                     tick_end;

  assign tick_end = (tick == '0);
  assign busy_o   = (state != ST_IDLE);

  // ==========================================================
  // sequencer
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state                  <= ST_IDLE;
      tick                   <= '0;
      edges                  <= 16'h0000;
      word                   <= '0;
      link.prog_clk          <= 1'b1;
      link.ser_din           <= 1'b0;
      link.cs_n              <= 1'b1;
      link.update_n          <= 1'b1;
      link.load_mode_select  <= 1'b0;
      link.out_addr          <= '0;
      link.src_sel           <= '0;
      link.output_enable_bit <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          tick <= HALF_T;
          if (cmd_serial_i) begin
            // last device's bits sit on top and leave first
            word                  <= serial_word_i << 1;
            link.ser_din          <= serial_word_i[CHAIN_BITS-1];
            edges                 <= 16'(CHAIN_BITS);
            link.load_mode_select <= 1'b0;
            link.cs_n             <= 1'b0;
            link.update_n         <= 1'b1;
            state                 <= ST_HI;
          end else if (cmd_par_i) begin
            link.load_mode_select  <= 1'b1;
            link.cs_n              <= 1'b0;
            link.update_n          <= 1'b1;
            link.out_addr          <= par_addr_i;
            link.src_sel           <= par_sel_i;
            link.output_enable_bit <= par_en_i;
            edges                  <= 16'h0001;
            state                  <= ST_HI;
          end else if (cmd_update_i) begin
            // user must have loaded a full word before the first update
            link.cs_n     <= 1'b0;
            link.update_n <= 1'b0;
            tick          <= UPD_T;
            state         <= ST_UPD;
          end
        end
        ST_HI: begin
          if (!tick_end) begin
            tick <= tick - 8'h01;
          end else if (edges == 16'h0000) begin
            link.cs_n <= 1'b1;
            state     <= ST_IDLE;
          end else begin
            edges         <= edges - 16'h0001;
            tick          <= HALF_T;
            link.prog_clk <= 1'b0;
            state         <= ST_LO;
          end
        end
        ST_LO: begin
          if (!tick_end) begin
            tick <= tick - 8'h01;
          end else begin
            // data moves on the rising edge, far from the sampling edge
            link.prog_clk <= 1'b1;
            link.ser_din  <= word[CHAIN_BITS-1];
            word          <= word << 1;
            tick          <= HALF_T;
            state         <= ST_HI;
          end
        end
        ST_UPD: begin
          if (!tick_end) begin
            tick <= tick - 8'h01;
          end else begin
            link.update_n <= 1'b1;
            link.cs_n     <= 1'b1;
            state         <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // disable pin and chain readback
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link.outputs_off_n <= 1'b0;
    end else begin
      link.outputs_off_n <= ~outputs_off_i;
    end
  end

  logic dout_s1;
  logic dout_s2;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dout_s1 <= 1'b0;
      dout_s2 <= 1'b0;
    end else begin
      dout_s1 <= link.ser_dout;
      dout_s2 <= dout_s1;
    end
  end

  assign chain_out_o = dout_s2;

endmodule

// ==== verification/xpp_sva.sv ====
// Purpose: wire checks between the host and device ends
// Assumes: host built with default timing and CHAIN_BITS of 32
// Notes:   sees link pins only; device latency is judged by the bench

`timescale 1ns/10ps

module xpp_sva
  import xpp_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic              prog_clk,
  input  wire logic              ser_din,
  input  wire logic              cs_n,
  input  wire logic              update_n,
  input  wire logic              load_mode_select,
  input  wire logic [ADDR_W-1:0] out_addr
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // ====================================
  // falls counted in one select window
  logic [5:0] falls;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      falls <= 6'h00;
    end else if (cs_n) begin
      falls <= 6'h00;
    end else if ($fell(prog_clk)) begin
      falls <= falls + 6'h01;
    end
  end

  // ====================================
  // assertions
  prog_idle_a: assert property (cs_n |-> prog_clk)
    else $error("programming clock not idle high");
  par_setup_a: assert property ($fell(prog_clk) && load_mode_select
    |-> !cs_n && update_n)
    else $error("parallel edge without setup");
  ser_hold_a: assert property ($fell(prog_clk) |-> update_n)
    else $error("clock edge while update low");
  upd_sel_a: assert property (!update_n |-> !cs_n && prog_clk)
    else $error("update low without select");
  upd_len_a: assert property ($fell(update_n) |-> (!update_n)[*4])
    else $error("update pulse too short");
  clk_low_a: assert property ($fell(prog_clk) |-> (!prog_clk)[*3])
    else $error("clock low phase too short");
  pins_still_a: assert property ($fell(prog_clk) |-> $stable({ser_din, out_addr})[*3])
    else $error("data moved around a clock fall");
  ser_count_a: assert property ($rose(cs_n) && !load_mode_select && $past(update_n)
    |-> falls == 6'd32)
    else $error("serial frame not 32 bits");
  par_count_a: assert property ($rose(cs_n) && load_mode_select && $past(update_n)
    |-> falls == 6'd1)
    else $error("parallel write not one edge");
  mode_hold_a: assert property (!cs_n && !$past(cs_n) |-> $stable(load_mode_select))
    else $error("mode changed inside a window");
endmodule

// ==== verification/test_crosspoint_matrix_programming_port.sv ====
// Purpose: host and device ends joined, checked at the user sides
// Assumes: default host timing; one device on the chain
// Notes:   expected matrix is rebuilt here from the slot layout

`timescale 1ns/10ps

module test_crosspoint_matrix_programming_port;
  import xpp_pkg::*;

  logic                          mclk_i, reset_n_i, busy_o, chain_out_o;
  logic                          cmd_serial_i, cmd_par_i, cmd_update_i, outputs_off_i;
  logic [WORD_W-1:0]             serial_word_i, shift_word_o, exp_sh, exp_lat;
  logic [ADDR_W-1:0]             par_addr_i;
  logic [SEL_W-1:0]              par_sel_i;
  logic                          par_en_i, frame_done_o, par_write_o;
  logic [NUM_OUT-1:0]            out_en_o;
  logic [NUM_OUT-1:0][SEL_W-1:0] out_sel_o;
  logic [NUM_OUT-1:0][NUM_IN-1:0] xpoint_o;
  int                            fail_count, n_compared, frames, pwr;

  xpp_link_if lk ();
  xpp_host xpp_host_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(lk.host),
    .cmd_serial_i(cmd_serial_i), .serial_word_i(serial_word_i), .cmd_par_i(cmd_par_i),
    .par_addr_i(par_addr_i), .par_sel_i(par_sel_i), .par_en_i(par_en_i),
    .cmd_update_i(cmd_update_i), .outputs_off_i(outputs_off_i), .busy_o(busy_o),
    .chain_out_o(chain_out_o));
  xpp_device xpp_device_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(lk.device),
    .out_en_o(out_en_o), .out_sel_o(out_sel_o), .xpoint_o(xpoint_o),
    .shift_word_o(shift_word_o), .frame_done_o(frame_done_o), .par_write_o(par_write_o));
  xpp_sva xpp_sva_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .prog_clk(lk.prog_clk),
    .ser_din(lk.ser_din), .cs_n(lk.cs_n), .update_n(lk.update_n),
    .load_mode_select(lk.load_mode_select), .out_addr(lk.out_addr));

  // ====================================
  // clock, pulse counters, watchdog
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(negedge mclk_i) begin
    if (frame_done_o === 1'b1) frames++;
    if (par_write_o === 1'b1) pwr++;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ====================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic run_cmd(input int kind);
    int n;
    @(negedge mclk_i);
    cmd_serial_i = (kind == 0);
    cmd_par_i    = (kind == 1);
    cmd_update_i = (kind == 2);
    @(negedge mclk_i);
    {cmd_serial_i, cmd_par_i, cmd_update_i} = 3'h0;
    check(32'(busy_o), 32'h1, "busy after command");
    n = 0;
    while (busy_o !== 1'b0 && n < 3000) begin
      @(negedge mclk_i);
      n++;
    end
    check(32'(n < 3000), 32'h1, "command never ended");
    repeat (6) @(negedge mclk_i);
  endtask

  // a disabled slot connects nothing whatever its select bits say
  task automatic chk_mat(input logic [31:0] lat, input logic off);
    logic       en;
    logic [2:0] sel;
    for (int k = 0; k < NUM_OUT; k++) begin
      en  = lat[4*k] & ~off;
      sel = lat[4*k+1 +: 3];
      check(32'(out_en_o[k]), 32'(en), "output enable");
      check(32'(out_sel_o[k]), 32'(sel), "latched select");
      check(32'(xpoint_o[k]), 32'(en ? (8'h01 << sel) : 8'h00), "crosspoint");
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ====================================
  // tests
  initial begin
    reset_n_i = 1'b0;
    {cmd_serial_i, cmd_par_i, cmd_update_i, outputs_off_i, par_en_i} = 5'h00;
    serial_word_i = 32'h0000_0000;
    par_addr_i = 3'h0;
    par_sel_i = 3'h0;
    repeat (3) @(negedge mclk_i);
    reset_n_i = 1'b1;
    chk_mat(32'h0, 1'b0);
    check(shift_word_o, 32'h0, "word after reset");
    $display("test reset done");

    exp_sh = 32'h9e2b_70c5;
    serial_word_i = exp_sh;
    run_cmd(0);
    check(shift_word_o, exp_sh, "serial word");
    check(32'(lk.ser_dout), 32'(exp_sh[31]), "serial out bit");
    check(32'(chain_out_o), 32'(exp_sh[31]), "chain readback");
    check(32'(frames), 32'h1, "frame pulses");
    chk_mat(32'h0, 1'b0);
    run_cmd(2);
    exp_lat = exp_sh;
    chk_mat(exp_lat, 1'b0);
    $display("test serial done");

    // batch of writes, one update at the end
    for (int a = 0; a < NUM_OUT; a++) begin
      par_addr_i = 3'(a);
      par_sel_i = 3'(7 - a);
      par_en_i = ~a[0];
      run_cmd(1);
      exp_sh[4*a +: 4] = {3'(7 - a), ~a[0]};
    end
    check(shift_word_o, exp_sh, "parallel slots");
    check(32'(pwr), 32'h8, "write pulses");
    check(32'(chain_out_o), 32'(exp_sh[31]), "chain after writes");
    chk_mat(exp_lat, 1'b0);
    run_cmd(2);
    exp_lat = exp_sh;
    chk_mat(exp_lat, 1'b0);
    par_addr_i = 3'h5;
    par_sel_i = 3'h3;
    par_en_i = 1'b1;
    run_cmd(1);
    run_cmd(2);
    exp_lat[23:20] = 4'h7;
    chk_mat(exp_lat, 1'b0);
    $display("test parallel done");

    outputs_off_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk_mat(exp_lat, 1'b1);
    check(shift_word_o, exp_lat, "word kept when off");
    outputs_off_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk_mat(exp_lat, 1'b0);
    $display("test disable done");
    tally_and_finish();
  end
endmodule
